// ===== inc/spd_params.svh
// Summary of operation
// [R01] selector nibble all ones selects frame pulse
// [R02] low sixteen bits count related periods between pulses
// [R03] selector picks sibling B/C/D; pulse one period
// [R04] software never selects this divider as reference
// [R05] polarity bit zero normal, one inverted pulse
// [R06] type zero straddles boundary, one edge-aligned
// [R07] normal mode divides oscillator by whole setting
// [R08] software keeps normal ratio at most maximum
// [R09] new setting applies once all bytes written
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH

// byte addresses of the three setting bytes, high byte first
`define SPD_ADDR_HI 8'hA4
`define SPD_ADDR_MID 8'hA5
`define SPD_ADDR_LO 8'hA6

// reset value of the setting
`define SPD_RESET_CFG 24'h000000

// shape selector value for frame pulse
`define SPD_FRAME_SHAPE 4'hF

// smallest ratio that yields a toggling clock
`define SPD_MIN_RATIO 24'h000002

// related clock selector codes
`define SPD_RSEL_RESERVED 2'h0
`define SPD_RSEL_B 2'h1
`define SPD_RSEL_C 2'h2
`define SPD_RSEL_D 2'h3

// byte lane codes and the full written mask
`define SPD_LANE_NONE 2'h0
`define SPD_LANE_HI 2'h1
`define SPD_LANE_MID 2'h2
`define SPD_LANE_LO 2'h3
`define SPD_MASK_NONE 3'h0
`define SPD_MASK_HI 3'h4
`define SPD_MASK_MID 3'h2
`define SPD_MASK_LO 3'h1
`define SPD_MASK_ALL 3'h7

// count constants
`define SPD_ONE24 24'h000001
`define SPD_ONE16 16'h0001
`define SPD_ZERO16 16'h0000
`define SPD_ZERO24 24'h000000
`define SPD_NUM_REL 3

`endif

// ===== inc/spd_pkg.sv
`include "spd_params.svh"

package spd_pkg;

    // one 24-bit setting split into its frame-pulse fields
    typedef struct packed {
        logic [3:0] shape;
        logic ptype;
        logic pol;
        logic [1:0] rsel;
        logic [15:0] period;
    } spd_cfg_t;

    // register port request carried as one bundle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spd_req_t;

    // frame shape test, used by the mode decode in spd_top
    function automatic logic is_frame(input spd_cfg_t cfg);
        is_frame = (cfg.shape == `SPD_FRAME_SHAPE);
    endfunction : is_frame

    // byte address to lane, shared by the write and read paths
    function automatic logic [1:0] addr_lane(input logic [7:0] addr);
        unique case (addr)
            `SPD_ADDR_HI: addr_lane = `SPD_LANE_HI;
            `SPD_ADDR_MID: addr_lane = `SPD_LANE_MID;
            `SPD_ADDR_LO: addr_lane = `SPD_LANE_LO;
            default: addr_lane = `SPD_LANE_NONE;
        endcase
    endfunction : addr_lane

endpackage : spd_pkg

// ===== core/spd_cfg_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "spd_params.svh"

module spd_cfg_regs (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire spd_pkg::spd_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output spd_pkg::spd_cfg_t o_cfg,
    output logic o_commit
);

    logic [23:0] stage_q;
    logic [23:0] stage_d;
    logic [2:0] mask_q;
    logic [2:0] mask_d;
    logic [1:0] wr_lane;
    logic [1:0] rd_lane;

    assign wr_lane = i_req.wr ? spd_pkg::addr_lane(i_req.addr) : `SPD_LANE_NONE;
    assign rd_lane = spd_pkg::addr_lane(i_req.addr);

    // merge the written byte into the staging word
    always_comb begin
        stage_d = stage_q;
        mask_d = mask_q;
        unique case (wr_lane)
            `SPD_LANE_HI: begin
                stage_d[23:16] = i_req.wdata;
                mask_d = mask_q | `SPD_MASK_HI;
            end
            `SPD_LANE_MID: begin
                stage_d[15:8] = i_req.wdata;
                mask_d = mask_q | `SPD_MASK_MID;
            end
            `SPD_LANE_LO: begin
                stage_d[7:0] = i_req.wdata;
                mask_d = mask_q | `SPD_MASK_LO;
            end
            `SPD_LANE_NONE: begin
                stage_d = stage_q;
            end
        endcase
    end

    // staging bytes and written mask; mask clears on commit
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage_q <= `SPD_RESET_CFG;
            mask_q <= `SPD_MASK_NONE;
        end else begin
            stage_q <= stage_d;
            mask_q <= (mask_d == `SPD_MASK_ALL) ? `SPD_MASK_NONE : mask_d;
        end
    end

    // live setting moves only as a whole word, never half-written
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cfg <= `SPD_RESET_CFG;
            o_commit <= 1'b0;
        end else begin
            o_commit <= (mask_d == `SPD_MASK_ALL); // [R09]
            if (mask_d == `SPD_MASK_ALL) begin
                o_cfg <= stage_d; // [R09]
            end
        end
    end

    // registered read of the staged bytes; unmapped reads give zero
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            unique case (rd_lane)
                `SPD_LANE_HI: o_rdata <= i_req.rd ? stage_q[23:16] : 8'h00;
                `SPD_LANE_MID: o_rdata <= i_req.rd ? stage_q[15:8] : 8'h00;
                `SPD_LANE_LO: o_rdata <= i_req.rd ? stage_q[7:0] : 8'h00;
                `SPD_LANE_NONE: o_rdata <= 8'h00;
            endcase
        end
    end

endmodule : spd_cfg_regs
`default_nettype wire

// ===== core/spd_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "spd_params.svh"

module spd_top (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [2:0] i_rel_clk,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_clk_out,
    output logic o_frame_mode
);

    spd_pkg::spd_req_t req;
    spd_pkg::spd_cfg_t cfg;
    logic commit;

    // bundle the register port
    assign req.wr = i_reg_wr;
    assign req.rd = i_reg_rd;
    assign req.addr = i_reg_addr;
    assign req.wdata = i_reg_wdata;

    spd_cfg_regs u_regs (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_req(req),
        .o_rdata(o_reg_rdata),
        .o_rvalid(o_reg_rvalid),
        .o_cfg(cfg),
        .o_commit(commit)
    );

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------

    logic frame_sel;
    logic [23:0] ratio;
    logic ratio_ok;

    // whole word is the ratio in normal mode
    assign frame_sel = spd_pkg::is_frame(cfg); // [R01]
    assign ratio = cfg; // [R07]
    // a ratio under two cannot toggle; output then holds low
    assign ratio_ok = (ratio >= `SPD_MIN_RATIO);

    // ------------------------------------------------------------------
    // normal mode divider
    // ------------------------------------------------------------------

    logic [23:0] div_cnt_q;
    logic [23:0] div_last;
    logic [23:0] div_half;
    logic clk_norm;

    assign div_last = ratio - `SPD_ONE24;
    assign div_half = {1'b0, ratio[23:1]};

    // counter restarts on every commit so a new ratio starts cleanly
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_cnt_q <= `SPD_ZERO24;
        end else if (commit || frame_sel || !ratio_ok) begin
            div_cnt_q <= `SPD_ZERO24;
        end else if (div_cnt_q >= div_last) begin
            div_cnt_q <= `SPD_ZERO24; // [R07]
        end else begin
            div_cnt_q <= div_cnt_q + `SPD_ONE24; // [R07]
        end
    end

    // high for floor(n/2); odd ratios run half a cycle short of half
    assign clk_norm = ratio_ok && (div_cnt_q < div_half); // [R07]

    // ------------------------------------------------------------------
    // related clock synchronisers
    // ------------------------------------------------------------------

    logic [2:0] rel_s1_q;
    logic [2:0] rel_s2_q;
    logic [2:0] rel_s3_q;

    // siblings run on their own divided phase, so sample them twice
    genvar gi;
    generate
        for (gi = 0; gi < `SPD_NUM_REL; gi = gi + 1) begin : g_rel_sync
            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    rel_s1_q[gi] <= 1'b0;
                    rel_s2_q[gi] <= 1'b0;
                    rel_s3_q[gi] <= 1'b0;
                end else begin
                    rel_s1_q[gi] <= i_rel_clk[gi];
                    rel_s2_q[gi] <= rel_s1_q[gi];
                    rel_s3_q[gi] <= rel_s2_q[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // related clock selection
    // ------------------------------------------------------------------

    logic rel_now;
    logic rel_old;
    logic rel_ok;

    // code 00 would be this divider itself, so it selects nothing
    always_comb begin
        rel_now = 1'b0;
        rel_old = 1'b0;
        rel_ok = 1'b1;
        unique case (cfg.rsel)
            `SPD_RSEL_B: begin
                rel_now = rel_s2_q[0]; // [R03]
                rel_old = rel_s3_q[0];
            end
            `SPD_RSEL_C: begin
                rel_now = rel_s2_q[1]; // [R03]
                rel_old = rel_s3_q[1];
            end
            `SPD_RSEL_D: begin
                rel_now = rel_s2_q[2]; // [R03]
                rel_old = rel_s3_q[2];
            end
            `SPD_RSEL_RESERVED: begin
                rel_ok = 1'b0; // [R04]
            end
        endcase
    end

    logic rel_rise;
    logic rel_fall;
    logic frame_ok;

    assign rel_rise = rel_now && !rel_old;
    assign rel_fall = !rel_now && rel_old;
    // a zero period means no pulses at all
    assign frame_ok = frame_sel && rel_ok && (cfg.period != `SPD_ZERO16);

    // ------------------------------------------------------------------
    // frame period counter
    // ------------------------------------------------------------------

    logic [15:0] per_cnt_q;
    logic [15:0] per_last;
    logic at_last;

    assign per_last = cfg.period - `SPD_ONE16;
    assign at_last = (per_cnt_q >= per_last);

    // counts related rising edges; wraps at the frame boundary
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            per_cnt_q <= `SPD_ZERO16;
        end else if (commit || !frame_ok) begin
            per_cnt_q <= `SPD_ZERO16;
        end else if (rel_rise) begin
            if (at_last) begin
                per_cnt_q <= `SPD_ZERO16; // [R02]
            end else begin
                per_cnt_q <= per_cnt_q + `SPD_ONE16; // [R02]
            end
        end
    end

    // ------------------------------------------------------------------
    // pulse shaping
    // ------------------------------------------------------------------

    logic pulse_q;

    // edge style: high from the boundary rise to the next rise;
    // straddle style: high from the fall before to the fall after,
    // so the boundary sits in the middle; either way one period wide
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pulse_q <= 1'b0;
        end else if (commit || !frame_ok) begin
            pulse_q <= 1'b0;
        end else if (cfg.ptype) begin
            if (rel_rise) begin
                pulse_q <= at_last; // [R06] [R03]
            end
        end else begin
            if (rel_fall) begin
                pulse_q <= at_last; // [R06] [R03]
            end
        end
    end

    // ------------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------------

    // output comes from a flop so downstream sees no decode glitches
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_clk_out <= 1'b0;
            o_frame_mode <= 1'b0;
        end else begin
            o_frame_mode <= frame_sel; // [R01]
            if (frame_sel) begin
                o_clk_out <= pulse_q ^ cfg.pol; // [R05] [R01]
            end else begin
                o_clk_out <= clk_norm; // [R01] [R08]
            end
        end
    end

endmodule : spd_top
`default_nettype wire

// ===== verif/spd_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "spd_params.svh"

module spd_top_monitor (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [2:0] i_rel_clk,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_clk_out,
    input wire logic o_frame_mode
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    logic [7:0] stg_q [3];
    logic [3:0] quiet_q;
    logic [1:0] idx;
    logic [1:0] sel;
    logic mapped;
    logic [7:0] rd_exp;
    logic rel_pick;
    // expected read byte, zero off the map
    assign mapped = i_reg_addr inside {`SPD_ADDR_HI, `SPD_ADDR_MID, `SPD_ADDR_LO};
    assign idx = 2'(i_reg_addr - `SPD_ADDR_HI);
    assign rd_exp = mapped ? stg_q[idx] : 8'h00;
    assign sel = stg_q[0][1:0] - 2'h1;
    // selected sibling pin as a plain signal, so the history below looks at one net
    assign rel_pick = i_rel_clk[sel];
    // shadow of staged bytes
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn)
            stg_q <= '{default: 8'h00};
        else if (i_reg_wr && mapped)
            stg_q[idx] <= i_reg_wdata;
    end
    // cycles since last write, saturating so it never wraps
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn)
            quiet_q <= 4'hF;
        else if (i_reg_wr)
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hF)
            quiet_q <= quiet_q + 4'h1;
    end
    chk_rvalid_after_rd: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    chk_rvalid_has_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("answer without read");
    chk_read_staged_byte: assert property (i_reg_rd |=> o_reg_rdata == $past(rd_exp))
        else $error("read byte wrong");
    chk_rdata_idle_zero: assert property (!o_reg_rvalid |-> o_reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    chk_mode_after_write: assert property ($changed(o_frame_mode) |-> quiet_q <= 4'h3)
        else $error("mode changed without a commit");
    chk_mode_rise_shape: assert property ($rose(o_frame_mode) |-> stg_q[0][7:4] == 4'hF)
        else $error("frame mode without all ones selector");
    chk_mode_fall_shape: assert property ($fell(o_frame_mode) |-> stg_q[0][7:4] != 4'hF)
        else $error("frame mode left with all ones selector");
    chk_pulse_edge_cause: assert property (quiet_q == 4'hF && o_frame_mode && stg_q[0][1:0] != 2'h0
        && $changed(o_clk_out) |-> $past(rel_pick, 4) != $past(rel_pick, 5)
        || $past(rel_pick, 5) != $past(rel_pick, 6)
        || $past(rel_pick, 6) != $past(rel_pick, 7))
        else $error("pulse edge not caused by related clock");
    cov_frame_on: cover property ($rose(o_frame_mode));
    cov_read_data: cover property (o_reg_rvalid && o_reg_rdata != 8'h00);
    cov_normal_clk: cover property (!o_frame_mode && $rose(o_clk_out));
endmodule : spd_top_monitor

bind spd_top spd_top_monitor u_mon (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_rel_clk(i_rel_clk),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_clk_out(o_clk_out),
    .o_frame_mode(o_frame_mode));
`default_nettype wire

// ===== verif/spd_rel_model.sv
`timescale 1ns/100ps
`default_nettype none

module spd_rel_model (
    input wire logic i_mclk,
    input wire logic i_resetn,
    output logic [2:0] o_rel_clk
);
    logic [4:0] cnt_q;
    // sibling dividers run free: periods 4, 6 and 8 mclk
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= 5'h00;
            o_rel_clk <= 3'h0;
        end else begin
            cnt_q <= (cnt_q == 5'h17) ? 5'h00 : cnt_q + 5'h01;
            o_rel_clk <= {cnt_q % 5'h08 >= 5'h04, cnt_q % 5'h06 >= 5'h03, cnt_q % 5'h04 >= 5'h02};
        end
    end
endmodule : spd_rel_model
`default_nettype wire

// ===== verif/tb_synth_post_divider_frame_pulse.sv
`timescale 1ns/100ps
`default_nettype none
`include "spd_params.svh"

module tb_synth_post_divider_frame_pulse;
    logic i_mclk, i_resetn, i_reg_wr, i_reg_rd, o_reg_rvalid, o_clk_out, o_frame_mode;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [2:0] i_rel_clk;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int act, per;
    spd_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_rel_clk(i_rel_clk), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .o_clk_out(o_clk_out), .o_frame_mode(o_frame_mode));
    spd_rel_model u_rel (.i_mclk(i_mclk), .i_resetn(i_resetn), .o_rel_clk(i_rel_clk));
    // 25 ns clock and a hang guard
    initial begin
        i_mclk = 1'h0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic step();
        @(posedge i_mclk);
        #2;
    endtask : step
    // writes n bytes from the high byte, strobe held through the burst
    task automatic cfg(input logic [23:0] v, input int n);
        step();
        i_reg_wr = 1'h1;
        for (int k = 0; k < n; k++) begin
            i_reg_addr = `SPD_ADDR_HI + 8'(k);
            i_reg_wdata = v[23 - 8 * k -: 8];
            step();
        end
        i_reg_wr = 1'h0;
        repeat (8) step();
    endtask : cfg
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        step();
        i_reg_rd = 1'h1;
        i_reg_addr = a;
        step();
        i_reg_rd = 1'h0;
        check(o_reg_rvalid, 1);
        check(o_reg_rdata, exp);
    endtask : rd
    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (o_clk_out !== lvl && n < 3000) begin
            step();
            n++;
        end
        if (n == 3000)
            check(o_clk_out, lvl);
    endtask : wait_lvl
    // active run and full period of the output
    task automatic measure(input logic lvl);
        int rest;
        wait_lvl(!lvl, rest);
        wait_lvl(lvl, rest);
        wait_lvl(!lvl, act);
        wait_lvl(lvl, rest);
        per = act + rest;
    endtask : measure
    task automatic hold(input logic lvl);
        repeat (40) begin
            step();
            check(o_clk_out, lvl);
        end
    endtask : hold
    task automatic t_reset();
        check(o_frame_mode, 0);
        for (int k = 0; k < 3; k++)
            rd(`SPD_ADDR_HI + 8'(k), 8'h00);
        hold(1'h0);
    endtask : t_reset
    task automatic t_regs();
        cfg(24'h123456, 3);
        rd(`SPD_ADDR_HI, 8'h12);
        rd(`SPD_ADDR_MID, 8'h34);
        rd(`SPD_ADDR_LO, 8'h56);
        rd(8'hA7, 8'h00);
    endtask : t_regs
    // ratios kept far below the normal maximum
    task automatic t_normal();
        int r [4] = '{5, 6, 256, 2};
        foreach (r[i]) begin
            cfg(24'(r[i]), 3);
            measure(1'h1);
            check(act, r[i] / 2);
            check(per, r[i]);
        end
        cfg(24'h000001, 3);
        hold(1'h0);
    endtask : t_normal
    // two bytes only must not commit the frame shape
    task automatic t_partial();
        cfg(24'hF90003, 2);
        check(o_frame_mode, 0);
        cfg(24'hF90003, 3);
        check(o_frame_mode, 1);
    endtask : t_partial
    task automatic t_frame();
        for (int k = 1; k < 4; k++) begin
            cfg({4'hF, 1'h1, 1'h0, 2'(k), 16'h0003}, 3);
            measure(1'h1);
            check(act, 2 * k + 2);
            check(per, 6 * k + 6);
        end
        cfg({4'hF, 1'h1, 1'h1, 2'h3, 16'h0002}, 3);
        measure(1'h0);
        check(act, 8);
        check(per, 16);
        for (int t = 0; t < 2; t++) begin
            cfg({4'hF, 1'(t), 1'h0, 2'h3, 16'h0002}, 3);
            wait_lvl(1'h0, act);
            wait_lvl(1'h1, act);
            check(i_rel_clk[2], !t);
        end
        cfg({4'hF, 1'h0, 1'h1, 2'h0, 16'h0003}, 3);
        hold(1'h1);
        cfg({4'hF, 1'h0, 1'h0, 2'h1, 16'h0000}, 3);
        hold(1'h0);
        cfg(24'h000006, 3);
        check(o_frame_mode, 0);
    endtask : t_frame
    initial begin
        i_resetn = 1'h0;
        i_reg_wr = 1'h0;
        i_reg_rd = 1'h0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        repeat (16) @(posedge i_mclk);
        #2 i_resetn = 1'h1;
        t_reset();
        t_regs();
        t_normal();
        t_partial();
        t_frame();
        summarize();
    end
endmodule : tb_synth_post_divider_frame_pulse
`default_nettype wire
